/* File: shared/cot_defs.svh */
// constants for the charger option and throttle configuration block
`ifndef COT_DEFS_SVH
`define COT_DEFS_SVH

// register byte addresses on the two-wire bus
`define COT_OFS_OPT3_LOW        8'h34
`define COT_OFS_THR_LOW         8'h36
`define COT_OFS_THR_HIGH        8'h37

// reset values
`define COT_RST_OPT3_LOW        8'h30
`define COT_RST_THR             16'h4a61

// charge option three low byte fields
`define COT_B_PIN_SEL           5
`define COT_B_CLAMP_HI          4
`define COT_B_CLAMP_LO          3
`define COT_B_RANGE_LOW         2
`define COT_B_BAT_OFF           1
`define COT_B_PWR_SRC           0

// throttle option zero fields (16-bit view)
`define COT_F_OVL_HI            15
`define COT_F_OVL_LO            11
`define COT_F_DEG_HI            10
`define COT_F_DEG_LO            9
`define COT_B_VIN_SEL           8
`define COT_F_SYS_HI            7
`define COT_F_SYS_LO            4
`define COT_B_VIN_LOWER         0

// inductor clamp levels in amps
`define COT_CLAMP_A0            5'h06
`define COT_CLAMP_A1            5'h0a
`define COT_CLAMP_A2            5'h0f

// reverse boost ranges in mV
`define COT_BOOST_HI_MIN_MV     15'h10b8
`define COT_BOOST_HI_MAX_MV     15'h5140
`define COT_BOOST_LO_MIN_MV     15'h0bb8
`define COT_BOOST_LO_MAX_MV     15'h4c40

// overload threshold code map, percent of input current limit
`define COT_OVL_FINE_FIRST      5'h01
`define COT_OVL_FINE_LAST       5'h19
`define COT_OVL_COARSE_FIRST    5'h1a
`define COT_OVL_COARSE_LAST     5'h1e
`define COT_OVL_FINE_BASE       9'h06e
`define COT_OVL_FINE_STEP       9'h005
`define COT_OVL_COARSE_BASE     9'h0fa
`define COT_OVL_COARSE_STEP     9'h032

// percentages used by the comparators
`define COT_PCT_FULL            34'h64
`define COT_PCT_CRIT            34'h6e
`define COT_PCT_VIN_80          34'h50
`define COT_PCT_VIN_90          34'h5a

// system voltage threshold map in mV
`define COT_SYS_MULTI_BASE_MV   13'h170c
`define COT_SYS_SINGLE_BASE_MV  13'h0c1c
`define COT_SYS_STEP_MV         13'h0064

// timing
`define COT_CLK_MHZ             250
`define COT_CRIT_DEG_0_US       15
`define COT_CRIT_DEG_1_US       100
`define COT_CRIT_DEG_2_US       400
`define COT_CRIT_DEG_3_US       800
`define COT_SYS_DEG_US          5

`endif

/* File: shared/cot_pkg.sv */
// types for the charger option and throttle configuration block
`default_nettype none
package cot_pkg;

  typedef enum logic [3:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ADDR_ACK,
    I2C_PTR,
    I2C_PTR_ACK,
    I2C_WDATA,
    I2C_WDATA_ACK,
    I2C_RDATA,
    I2C_RDATA_ACK
  } cot_i2c_e;

  typedef logic [7:0]  cot_byte_t;
  typedef logic [33:0] cot_wide_t;

endpackage
`default_nettype wire

/* File: src/cot_config_top.sv */
// charger option and throttle configuration registers behind a two-wire slave
`timescale 1ns/10ps
`default_nettype none
`include "cot_defs.svh"
// Contract
// - bit5 routes assist pin to peak-assist or boost
// - bits4-3 select 6/10/15 A clamp or none
// - bit2 selects high or low boost range
// - bit1 turns battery switch off in hiz
// - bit0 picks power monitor source in boost
// - five-bit overload code maps to percent limit
// - overload trips above threshold; resets to 150%
// - critical threshold is 110% of overload threshold
// - deglitch code sets critical throttle delay
// - lower enable set: 80% or 90% setpoint
// - sys voltage below threshold starts bus discharge while peak-assist is active
// - sys codes map per cell count, 0.1V steps
// - throttle register loads 16'h4a61 at reset
// - lower enable clear: comparator uses setpoint itself
module cot_config_top #(
  parameter logic [6:0]  DevAddr      = 7'h2a, // arbitrary bus address
  parameter int unsigned CritDeg0Cyc  = `COT_CRIT_DEG_0_US * `COT_CLK_MHZ,
  parameter int unsigned CritDeg1Cyc  = `COT_CRIT_DEG_1_US * `COT_CLK_MHZ,
  parameter int unsigned CritDeg2Cyc  = `COT_CRIT_DEG_2_US * `COT_CLK_MHZ,
  parameter int unsigned CritDeg3Cyc  = `COT_CRIT_DEG_3_US * `COT_CLK_MHZ
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // two-wire serial bus
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // mode pins and status
  input  wire logic        assistPin,
  input  wire logic        hizMode,
  input  wire logic        reverseBoostActive,
  input  wire logic        peakAssistActive,
  input  wire logic        singleCell,
  // measurements
  input  wire logic [15:0] inputCurrentMa,
  input  wire logic [15:0] inputCurrentLimitMa,
  input  wire logic [15:0] vinMv,
  input  wire logic [15:0] inputVoltageSetpointMv,
  input  wire logic [15:0] sysMv,
  // decoded configuration
  output logic             peakAssistPinEn,
  output logic             reverseBoostPinEn,
  output logic      [4:0]  inductorClampAmps,
  output logic             inductorClampOff,
  output logic      [14:0] boostMinMv,
  output logic      [14:0] boostMaxMv,
  output logic             batterySwitchOn,
  output logic             powerMonitorSubtractBoost,
  output logic      [12:0] sysThresholdMv,
  // throttle results
  output logic             overloadDetect,
  output logic             throttleOutput,
  output logic             vinThrottle,
  output logic             busDischarge
);

  localparam int unsigned SysDegCyc = `COT_SYS_DEG_US * `COT_CLK_MHZ;

  cot_pkg::cot_i2c_e  state_r;
  logic               sclPrev_r;
  logic               sdaPrev_r;
  logic [3:0]         bitCnt_r;
  cot_pkg::cot_byte_t shift_r;
  cot_pkg::cot_byte_t ptr_r;
  logic               isRead_r;
  logic               rxNack_r;
  logic               sdaOe_r;
  cot_pkg::cot_byte_t opt3_r;
  logic [15:0]        thr_r;
  cot_pkg::cot_byte_t rdByte;
  logic               sclRise;
  logic               sclFall;
  logic               busStart;
  logic               busStop;
  logic               byteIn;
  logic               ptrLoad;
  logic               wrStb;
  logic               rdLoad;

  // bus edges; pins are already synchronous to clk
  assign sclRise  = sclIn & ~sclPrev_r;
  assign sclFall  = ~sclIn & sclPrev_r;
  assign busStart = sclIn & sclPrev_r & sdaPrev_r & ~sdaIn;
  assign busStop  = sclIn & sclPrev_r & ~sdaPrev_r & sdaIn;
  assign byteIn   = sclFall && bitCnt_r == 4'h8;
  assign ptrLoad  = byteIn && state_r == cot_pkg::I2C_PTR;
  assign wrStb    = byteIn && state_r == cot_pkg::I2C_WDATA;
  assign rdLoad   = sclFall && ((state_r == cot_pkg::I2C_ADDR_ACK && isRead_r) ||
                               (state_r == cot_pkg::I2C_RDATA_ACK && !rxNack_r));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else
    begin
      sclPrev_r <= sclIn;
      sdaPrev_r <= sdaIn;
    end
  end

  // read mux; unmapped byte addresses read as zero
  always_comb
  begin
    if (ptr_r == `COT_OFS_OPT3_LOW)
      rdByte = opt3_r;
    else if (ptr_r == `COT_OFS_THR_LOW)
      rdByte = thr_r[7:0];
    else if (ptr_r == `COT_OFS_THR_HIGH)
      rdByte = thr_r[15:8];
    else
      rdByte = 8'h00;
  end

  // serial slave sequencing: address, pointer, then data bytes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r  <= cot_pkg::I2C_IDLE;
      bitCnt_r <= 4'h0;
      shift_r  <= 8'h00;
      isRead_r <= 1'b0;
      rxNack_r <= 1'b0;
      sdaOe_r  <= 1'b0;
    end
    else if (busStart)
    begin
      state_r  <= cot_pkg::I2C_ADDR;
      bitCnt_r <= 4'h0;
      sdaOe_r  <= 1'b0;
    end
    else if (busStop)
    begin
      state_r <= cot_pkg::I2C_IDLE;
      sdaOe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        cot_pkg::I2C_ADDR, cot_pkg::I2C_PTR, cot_pkg::I2C_WDATA:
        begin
          if (sclRise)
          begin
            shift_r  <= {shift_r[6:0], sdaIn};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          else if (byteIn)
          begin
            bitCnt_r <= 4'h0;
            if (state_r == cot_pkg::I2C_ADDR)
            begin
              // a foreign address leaves the bus untouched until the next start
              if (shift_r[7:1] == DevAddr)
              begin
                state_r  <= cot_pkg::I2C_ADDR_ACK;
                isRead_r <= shift_r[0];
                sdaOe_r  <= 1'b1;
              end
              else
                state_r <= cot_pkg::I2C_IDLE;
            end
            else if (state_r == cot_pkg::I2C_PTR)
            begin
              state_r <= cot_pkg::I2C_PTR_ACK;
              sdaOe_r <= 1'b1;
            end
            else
            begin
              state_r <= cot_pkg::I2C_WDATA_ACK;
              sdaOe_r <= 1'b1;
            end
          end
        end
        cot_pkg::I2C_ADDR_ACK, cot_pkg::I2C_RDATA_ACK:
        begin
          if (sclRise && state_r == cot_pkg::I2C_RDATA_ACK)
            rxNack_r <= sdaIn;
          else if (rdLoad)
          begin
            state_r  <= cot_pkg::I2C_RDATA;
            shift_r  <= rdByte;
            sdaOe_r  <= ~rdByte[7];
            bitCnt_r <= 4'h1;
          end
          else if (sclFall && state_r == cot_pkg::I2C_ADDR_ACK)
          begin
            state_r <= cot_pkg::I2C_PTR;
            sdaOe_r <= 1'b0;
          end
          else if (sclFall)
          begin
            state_r <= cot_pkg::I2C_IDLE;
            sdaOe_r <= 1'b0;
          end
        end
        cot_pkg::I2C_PTR_ACK, cot_pkg::I2C_WDATA_ACK:
        begin
          if (sclFall)
          begin
            state_r <= cot_pkg::I2C_WDATA;
            sdaOe_r <= 1'b0;
          end
        end
        cot_pkg::I2C_RDATA:
        begin
          if (byteIn)
          begin
            state_r  <= cot_pkg::I2C_RDATA_ACK;
            sdaOe_r  <= 1'b0;
            rxNack_r <= 1'b0;
          end
          else if (sclFall)
          begin
            sdaOe_r  <= ~shift_r[6];
            shift_r  <= {shift_r[6:0], 1'b0};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
        end
        default:
          sdaOe_r <= 1'b0;
      endcase
    end
  end

  // byte pointer auto-increments after every data byte either way
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ptr_r <= 8'h00;
    else if (ptrLoad)
      ptr_r <= shift_r;
    else if (wrStb || rdLoad)
      ptr_r <= ptr_r + 8'h01;
  end

  // charge option three low byte; reserved bits kept so they read back
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      opt3_r <= `COT_RST_OPT3_LOW;
    else if (wrStb && ptr_r == `COT_OFS_OPT3_LOW)
      opt3_r <= shift_r;
  end

  // throttle option zero, one byte lane per address
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      thr_r <= `COT_RST_THR;
    else if (wrStb && ptr_r == `COT_OFS_THR_LOW)
      thr_r[7:0] <= shift_r;
    else if (wrStb && ptr_r == `COT_OFS_THR_HIGH)
      thr_r[15:8] <= shift_r;
  end

  // decoded charge option outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      peakAssistPinEn           <= 1'b0;
      reverseBoostPinEn         <= 1'b0;
      inductorClampAmps         <= `COT_CLAMP_A2;
      inductorClampOff          <= 1'b0;
      boostMinMv                <= `COT_BOOST_HI_MIN_MV;
      boostMaxMv                <= `COT_BOOST_HI_MAX_MV;
      batterySwitchOn           <= 1'b1;
      powerMonitorSubtractBoost <= 1'b0;
    end
    else
    begin
      peakAssistPinEn   <= assistPin & ~opt3_r[`COT_B_PIN_SEL];
      reverseBoostPinEn <= assistPin & opt3_r[`COT_B_PIN_SEL];
      case (opt3_r[`COT_B_CLAMP_HI:`COT_B_CLAMP_LO])
        2'h0:    inductorClampAmps <= `COT_CLAMP_A0;
        2'h1:    inductorClampAmps <= `COT_CLAMP_A1;
        default: inductorClampAmps <= `COT_CLAMP_A2;
      endcase
      inductorClampOff <= &opt3_r[`COT_B_CLAMP_HI:`COT_B_CLAMP_LO];
      boostMinMv <= opt3_r[`COT_B_RANGE_LOW] ? `COT_BOOST_LO_MIN_MV
                                             : `COT_BOOST_HI_MIN_MV;
      boostMaxMv <= opt3_r[`COT_B_RANGE_LOW] ? `COT_BOOST_LO_MAX_MV
                                             : `COT_BOOST_HI_MAX_MV;
      batterySwitchOn <= ~(hizMode & opt3_r[`COT_B_BAT_OFF]);
      powerMonitorSubtractBoost <= reverseBoostActive & ~opt3_r[`COT_B_PWR_SRC];
    end
  end

  // threshold comparators; scaled products avoid dividers
  logic [8:0]         ovlPct;
  logic               ovlValid;
  logic [12:0]        sysThrMv;
  cot_pkg::cot_wide_t curScaled;
  cot_pkg::cot_wide_t limScaled;
  cot_pkg::cot_wide_t vinScaled;
  cot_pkg::cot_wide_t setScaled;
  cot_pkg::cot_wide_t vinPct;
  logic               critRaw_r;
  logic               sysRaw_r;
  logic               critQual;
  logic               sysQual;
  logic [17:0]        critHold;

  cot_threshold_lut thresholds (
    .overloadThreshold         (thr_r[`COT_F_OVL_HI:`COT_F_OVL_LO]),
    .sysVoltageAssistThreshold (thr_r[`COT_F_SYS_HI:`COT_F_SYS_LO]),
    .singleCell                (singleCell),
    .overloadPct               (ovlPct),
    .overloadValid             (ovlValid),
    .sysThresholdMv            (sysThrMv)
  );

  always_comb
  begin
    if (!thr_r[`COT_B_VIN_LOWER])
      vinPct = `COT_PCT_FULL;
    else if (thr_r[`COT_B_VIN_SEL])
      vinPct = `COT_PCT_VIN_90;
    else
      vinPct = `COT_PCT_VIN_80;
  end

  assign curScaled = 34'(inputCurrentMa) * `COT_PCT_FULL;
  assign limScaled = 34'(inputCurrentLimitMa) * 34'(ovlPct);
  assign vinScaled = 34'(vinMv) * `COT_PCT_FULL;
  assign setScaled = 34'(inputVoltageSetpointMv) * vinPct;

  always_comb
  begin
    case (thr_r[`COT_F_DEG_HI:`COT_F_DEG_LO])
      2'h0:    critHold = 18'(CritDeg0Cyc);
      2'h1:    critHold = 18'(CritDeg1Cyc);
      2'h2:    critHold = 18'(CritDeg2Cyc);
      default: critHold = 18'(CritDeg3Cyc);
    endcase
  end

  // code 11111 and code 0 disable both current detectors
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      overloadDetect <= 1'b0;
      critRaw_r      <= 1'b0;
      vinThrottle    <= 1'b0;
      sysRaw_r       <= 1'b0;
      sysThresholdMv <= `COT_SYS_MULTI_BASE_MV;
    end
    else
    begin
      overloadDetect <= ovlValid && curScaled > limScaled;
      critRaw_r <= ovlValid &&
                   curScaled * `COT_PCT_FULL > limScaled * `COT_PCT_CRIT;
      vinThrottle <= vinScaled < setScaled;
      sysRaw_r <= sysMv < {3'h0, sysThrMv};
      sysThresholdMv <= sysThrMv;
    end
  end

  cot_deglitch #(
    .W (18)
  ) critDeglitch (
    .clk       (clk),
    .rstn      (rstn),
    .rawIn     (critRaw_r),
    .holdCyc   (critHold),
    .qualified (critQual)
  );

  cot_deglitch #(
    .W (18)
  ) sysDeglitch (
    .clk       (clk),
    .rstn      (rstn),
    .rawIn     (sysRaw_r),
    .holdCyc   (18'(SysDegCyc)),
    .qualified (sysQual)
  );

  // discharge only while peak-assist is running
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      throttleOutput <= 1'b0;
      busDischarge   <= 1'b0;
    end
    else
    begin
      throttleOutput <= critQual;
      busDischarge   <= sysQual & peakAssistActive;
    end
  end

  // open-drain bus: the line is only ever pulled low
  assign sdaOe  = sdaOe_r;
  assign sdaOut = 1'b0;

endmodule
`default_nettype wire

/* File: src/cot_deglitch.sv */
// hold-time qualifier: output rises once the input has stayed high long enough
`timescale 1ns/10ps
`default_nettype none
module cot_deglitch #(
  parameter int W = 18
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // raw condition and required hold in cycles
  input  wire logic         rawIn,
  input  wire logic [W-1:0] holdCyc,
  // qualified condition
  output logic              qualified
);

  logic [W-1:0] cnt_r;
  logic         qual_r;

  // any drop of the raw level restarts the wait, so chatter never adds up
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end
    else if (!rawIn)
    begin
      cnt_r  <= '0;
      qual_r <= 1'b0;
    end
    else if (cnt_r >= holdCyc - W'(1))
      qual_r <= 1'b1;
    else
      cnt_r <= cnt_r + W'(1);
  end

  assign qualified = qual_r;

endmodule
`default_nettype wire

/* File: src/cot_threshold_lut.sv */
// code-to-value tables for the overload and system voltage thresholds
`timescale 1ns/10ps
`default_nettype none
`include "cot_defs.svh"
module cot_threshold_lut (
  // threshold codes
  input  wire logic [4:0]  overloadThreshold,
  input  wire logic [3:0]  sysVoltageAssistThreshold,
  input  wire logic        singleCell,
  // decoded values
  output logic      [8:0]  overloadPct,
  output logic             overloadValid,
  output logic      [12:0] sysThresholdMv
);

  logic [3:0] sysIdx;

  always_comb
  begin
    overloadPct   = 9'h000;
    overloadValid = 1'b0;
    if (overloadThreshold >= `COT_OVL_FINE_FIRST && overloadThreshold <= `COT_OVL_FINE_LAST)
    begin
      overloadValid = 1'b1;
      overloadPct   = `COT_OVL_FINE_BASE + ({4'h0, overloadThreshold}
                      - {4'h0, `COT_OVL_FINE_FIRST}) * `COT_OVL_FINE_STEP;
    end
    else if (overloadThreshold >= `COT_OVL_COARSE_FIRST &&
             overloadThreshold <= `COT_OVL_COARSE_LAST)
    begin
      overloadValid = 1'b1;
      overloadPct   = `COT_OVL_COARSE_BASE + ({4'h0, overloadThreshold}
                      - {4'h0, `COT_OVL_COARSE_FIRST}) * `COT_OVL_COARSE_STEP;
    end
  end

  // single cell: upper half of the codes repeats the lower half
  always_comb
  begin
    sysIdx         = singleCell ? {1'b0, sysVoltageAssistThreshold[2:0]}
                                : sysVoltageAssistThreshold;
    sysThresholdMv = (singleCell ? `COT_SYS_SINGLE_BASE_MV : `COT_SYS_MULTI_BASE_MV)
                     + {9'h000, sysIdx} * `COT_SYS_STEP_MV;
  end

endmodule
`default_nettype wire

/* File: tb/cot_chk_sva.sv */
// port assertions for the configuration block
`timescale 1ns/10ps
`default_nettype none
module cot_chk (
  // clock, reset and bus
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        sclIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  // pins and measurements
  input wire logic        assistPin,
  input wire logic        hizMode,
  input wire logic        reverseBoostActive,
  input wire logic        peakAssistActive,
  input wire logic [15:0] inputCurrentMa,
  input wire logic [15:0] inputCurrentLimitMa,
  input wire logic [15:0] vinMv,
  input wire logic [15:0] inputVoltageSetpointMv,
  // outputs
  input wire logic        peakAssistPinEn,
  input wire logic        reverseBoostPinEn,
  input wire logic        batterySwitchOn,
  input wire logic        powerMonitorSubtractBoost,
  input wire logic        overloadDetect,
  input wire logic        throttleOutput,
  input wire logic        vinThrottle,
  input wire logic        busDischarge
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_OPEN_DRAIN: assert property (sdaOut == 1'h0)
    else $error("sda driven high");
  // a change with scl high would read as start or stop
  AST_SDA_ON_LOW: assert property ($changed(sdaOe) |-> !$past(sclIn))
    else $error("sda moved with scl high");
  AST_PIN_ROUTE: assert property ($past(rstn) |-> !(peakAssistPinEn && reverseBoostPinEn) &&
    (peakAssistPinEn || reverseBoostPinEn) == $past(assistPin)) else $error("pin routing");
  AST_BATT_HIZ: assert property ($past(rstn) && !$past(hizMode) |-> batterySwitchOn)
    else $error("switch off outside hiz");
  AST_MON_SRC: assert property ($past(rstn) && !$past(reverseBoostActive) |->
    !powerMonitorSubtractBoost) else $error("monitor source outside boost");
  // lowest code is 110 percent, so at or below that nothing may trip
  AST_OVL_FLOOR: assert property ($past(rstn) && 32'($past(inputCurrentMa)) * 100 <=
    32'($past(inputCurrentLimitMa)) * 110 |-> !overloadDetect) else $error("overload low");
  AST_VIN_FLOOR: assert property ($past(rstn) &&
    $past(vinMv) >= $past(inputVoltageSetpointMv) |-> !vinThrottle) else $error("vin high");
  AST_CRIT_HOLD: assert property ($rose(throttleOutput) |-> $past(overloadDetect, 8))
    else $error("throttle without held overload");
  AST_DISCH_MODE: assert property ((!peakAssistActive)[*3] |-> !busDischarge)
    else $error("discharge outside assist");
endmodule
bind cot_config_top cot_chk i_cot_chk (.clk, .rstn, .sclIn, .sdaOut, .sdaOe, .assistPin,
  .hizMode, .reverseBoostActive, .peakAssistActive, .inputCurrentMa, .inputCurrentLimitMa,
  .vinMv, .inputVoltageSetpointMv, .peakAssistPinEn, .reverseBoostPinEn, .batterySwitchOn,
  .powerMonitorSubtractBoost, .overloadDetect, .throttleOutput, .vinThrottle, .busDischarge);
`default_nettype wire

/* File: tb/cot_host.sv */
// two-wire bus host model for the configuration block
`timescale 1ns/10ps
`default_nettype none
module cot_host (
  // clock
  input  wire logic clk,
  // bus lines; a released sda reads high through the pull-up
  output var  logic scl,
  output var  logic sdaDrv,
  input  wire logic sdaWire
);
  initial
  begin
    scl = 1'h1;
    sdaDrv = 1'h1;
  end
  // four clocks a half period keeps each level over the two samples the slave needs
  task automatic hp();
    repeat (4) @(negedge clk);
  endtask
  // serves as first and repeated start alike
  task automatic start();
    @(negedge clk);
    sdaDrv = 1'h1;
    hp();
    scl = 1'h1;
    hp();
    sdaDrv = 1'h0;
    hp();
    scl = 1'h0;
  endtask
  task automatic stop();
    @(negedge clk);
    sdaDrv = 1'h0;
    hp();
    scl = 1'h1;
    hp();
    sdaDrv = 1'h1;
    hp();
  endtask
  // sda only moves a clock after scl falls, never while it is high
  task automatic bitx(input logic b, output logic r);
    @(negedge clk);
    sdaDrv = b;
    hp();
    scl = 1'h1;
    hp();
    r = sdaWire;
    scl = 1'h0;
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'h1, r);
    ack = !r;
  endtask
  task automatic rdByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'h1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the configuration block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [6:0] DevAddr = 7'h2a; // arbitrary bus address
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        sclIn, sdaDrv, sdaOut, sdaOe;
  logic        assistPin = 1'h0, hizMode = 1'h0, reverseBoostActive = 1'h0;
  logic        peakAssistActive = 1'h0, singleCell = 1'h0;
  logic [15:0] inputCurrentMa = 16'h0000, inputCurrentLimitMa = 16'h03e8, sysMv = 16'h1d4c;
  logic [15:0] vinMv = 16'h2710, inputVoltageSetpointMv = 16'h2710;
  logic        peakAssistPinEn, reverseBoostPinEn, inductorClampOff, batterySwitchOn;
  logic        powerMonitorSubtractBoost, overloadDetect, throttleOutput, vinThrottle;
  logic        busDischarge;
  logic [4:0]  inductorClampAmps;
  logic [14:0] boostMinMv, boostMaxMv;
  logic [12:0] sysThresholdMv;
  wire  logic  sdaIn = sdaDrv & (sdaOe ? sdaOut : 1'h1);
  int          fails = 0;
  int          checksDone = 0;
  int          cyc = 0;
  int          n;
  logic [7:0]  v;
  logic [4:0]  clampTbl [4] = '{5'h06, 5'h0a, 5'h0f, 5'h0f};
  logic [7:0]  opt3Tbl [5] = '{8'h00, 8'h2f, 8'hd5, 8'h1a, 8'h30};
  // {code, single cell, mV}
  logic [17:0] sysTbl [4] = '{{4'h0, 1'h0, 13'h170c}, {4'hf, 1'h0, 13'h1ce8},
    {4'h9, 1'h1, 13'h0c80}, {4'h7, 1'h1, 13'h0ed8}};
  // {level select, lower enable, vin mV, throttle}
  logic [18:0] vinTbl [5] = '{{2'h1, 16'h2134, 1'h0}, {2'h1, 16'h1f3f, 1'h1},
    {2'h3, 16'h2134, 1'h1}, {2'h0, 16'h270f, 1'h1}, {2'h0, 16'h2710, 1'h0}};
  // {code, current mA, overload}
  logic [21:0] ovlTbl [9] = '{{5'h09, 16'h05dc, 1'h0}, {5'h09, 16'h05dd, 1'h1},
    {5'h01, 16'h044c, 1'h0}, {5'h01, 16'h044d, 1'h1}, {5'h19, 16'h08fd, 1'h1},
    {5'h1a, 16'h09c4, 1'h0}, {5'h1e, 16'h1195, 1'h1}, {5'h1f, 16'hffff, 1'h0},
    {5'h00, 16'hffff, 1'h0}};

  cot_host i_cot_host (.clk, .scl(sclIn), .sdaDrv, .sdaWire(sdaIn));
  // short deglitch counts keep the run brief
  cot_config_top #(.DevAddr(DevAddr), .CritDeg0Cyc(10), .CritDeg1Cyc(20), .CritDeg2Cyc(30),
    .CritDeg3Cyc(40)) i_cot_config_top (.clk, .rstn, .sclIn, .sdaIn, .sdaOut, .sdaOe,
    .assistPin, .hizMode, .reverseBoostActive, .peakAssistActive, .singleCell,
    .inputCurrentMa, .inputCurrentLimitMa, .vinMv, .inputVoltageSetpointMv, .sysMv,
    .peakAssistPinEn, .reverseBoostPinEn, .inductorClampAmps, .inductorClampOff, .boostMinMv,
    .boostMaxMv, .batterySwitchOn, .powerMonitorSubtractBoost, .sysThresholdMv,
    .overloadDetect, .throttleOutput, .vinThrottle, .busDischarge);

  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 50000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic regWrite(input logic [7:0] ptr, input logic [7:0] d);
    logic [2:0] a;
    i_cot_host.start();
    i_cot_host.wrByte({DevAddr, 1'h0}, a[2]);
    i_cot_host.wrByte(ptr, a[1]);
    i_cot_host.wrByte(d, a[0]);
    i_cot_host.stop();
    chk(a, 3'h7);
    repeat (2) @(negedge clk);
  endtask
  task automatic regCheck(input logic [7:0] ptr, input logic [7:0] exp);
    logic [2:0] a;
    logic [7:0] d;
    i_cot_host.start();
    i_cot_host.wrByte({DevAddr, 1'h0}, a[2]);
    i_cot_host.wrByte(ptr, a[1]);
    i_cot_host.start();
    i_cot_host.wrByte({DevAddr, 1'h1}, a[0]);
    i_cot_host.rdByte(1'h1, d);
    i_cot_host.stop();
    chk(a, 3'h7);
    chk(d, exp);
  endtask
  task automatic riseAfter(ref logic sig, input int lim, output int cnt);
    cnt = 0;
    while (sig !== 1'h1 && cnt < lim)
    begin
      @(negedge clk);
      cnt++;
    end
  endtask

  initial
  begin
    repeat (8) @(negedge clk);
    rstn = 1'h1;
    repeat (4) @(negedge clk);
    chk(sysThresholdMv, 13'h1964);
    regCheck(8'h34, 8'h30);
    regCheck(8'h36, 8'h61);
    regCheck(8'h37, 8'h4a);
    regCheck(8'h35, 8'h00);
    i_cot_host.start();
    i_cot_host.wrByte({~DevAddr, 1'h0}, v[0]);
    chk(v[0], 1'h0);
    assistPin = 1'h1;
    hizMode = 1'h1;
    reverseBoostActive = 1'h1;
    foreach (opt3Tbl[i])
    begin
      v = opt3Tbl[i];
      regWrite(8'h34, v);
      regCheck(8'h34, v);
      chk({peakAssistPinEn, reverseBoostPinEn}, {!v[5], v[5]});
      chk({inductorClampOff, inductorClampAmps}, {&v[4:3], clampTbl[v[4:3]]});
      chk({boostMinMv, boostMaxMv}, v[2] ? {15'h0bb8, 15'h4c40} : {15'h10b8, 15'h5140});
      chk(batterySwitchOn, !v[1]);
      chk(powerMonitorSubtractBoost, !v[0]);
    end
    foreach (sysTbl[i])
    begin
      singleCell = sysTbl[i][13];
      regWrite(8'h36, {sysTbl[i][17:14], 4'h1});
      chk(sysThresholdMv, sysTbl[i][12:0]);
    end
    singleCell = 1'h0;
    foreach (vinTbl[i])
    begin
      regWrite(8'h37, {7'h25, vinTbl[i][18]});
      regWrite(8'h36, {7'h30, vinTbl[i][17]});
      vinMv = vinTbl[i][16:1];
      repeat (3) @(negedge clk);
      chk(vinThrottle, vinTbl[i][0]);
    end
    foreach (ovlTbl[i])
    begin
      inputCurrentMa = 16'h0000;
      regWrite(8'h37, {ovlTbl[i][21:17], 3'h0});
      inputCurrentMa = ovlTbl[i][16:1];
      repeat (3) @(negedge clk);
      chk(overloadDetect, ovlTbl[i][0]);
    end
    inputCurrentMa = 16'h0000;
    for (int d = 0; d < 4; d++)
    begin
      regWrite(8'h37, {5'h09, d[1:0], 1'h0});
      inputCurrentMa = 16'h0672;
      repeat (60) @(negedge clk);
      chk(throttleOutput, 1'h0);
      inputCurrentMa = 16'h0673;
      riseAfter(throttleOutput, 200, n);
      chk(n >= 10 * (d + 1) && n <= 10 * (d + 1) + 4, 1'h1);
      inputCurrentMa = 16'h0000;
      repeat (8) @(negedge clk);
    end
    peakAssistActive = 1'h1;
    sysMv = 16'h1963;
    riseAfter(busDischarge, 1400, n);
    chk(n >= 1250 && n <= 1256, 1'h1);
    sysMv = 16'h1964;
    repeat (6) @(negedge clk);
    chk(busDischarge, 1'h0);
    peakAssistActive = 1'h0;
    sysMv = 16'h1963;
    repeat (1300) @(negedge clk);
    chk(busDischarge, 1'h0);
    test_done();
  end
endmodule
`default_nettype wire
